/* core/slcb_bank.sv */
`timescale 1ns/10ps
module slcb_bank
  import slcb_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEFAULT,
  parameter int TURN_OFF_CYCLES = TURN_OFF_CYCLES_DEFAULT
) (
  // System clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Management link, link clock domain
  input wire logic link_clock_i,
  input wire logic link_req_valid_i,
  input wire slcb_link_req_t link_req_i,
  output logic link_ready_o,
  output logic link_rsp_valid_o,
  output slcb_link_rsp_t link_rsp_o,
  // Telemetry and control, system clock domain
  input wire logic [15:0] input_sense_pin_i,
  input wire logic [NUM_CHAN-1:0][15:0] vout_sense_i,
  input wire logic conversion_request_i,
  input wire logic [NUM_CHAN-1:0] channel_run_i,
  input wire logic [NUM_CHAN-1:0] track_enable_i,
  input wire logic [NUM_CHAN-1:0][1:0] margin_select_i,
  input wire logic good_off_uses_undervoltage_i,
  // Status and enables
  output logic conversion_on_o,
  output logic [NUM_CHAN-1:0] output_enable_pin_o,
  output slcb_vin_flags_t vin_flags_o,
  output slcb_chan_out_t [NUM_CHAN-1:0] chan_out_o,
  output logic store_busy_o
);

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    slcb_link_rsp_t rsp;
    logic [15:0] turn_on_level;
    logic [15:0] turn_off_level;
    logic [15:0] vin_ov_fault;
    logic [15:0] vin_ov_warn;
    logic [15:0] vin_uv_warn;
    logic [15:0] vin_uv_fault;
    slcb_chan_regs_t [NUM_CHAN-1:0] chan;
    slcb_store_state_t store;
    logic [23:0] store_count;
    logic conv_on;
    logic [NUM_CHAN-1:0] out_en;
    logic sd_active;
    logic [1:0] sd_idx;
    logic [15:0] sd_count;
    logic [NUM_CHAN-1:0] good;
    slcb_vin_flags_t vin_flags;
    slcb_chan_out_t [NUM_CHAN-1:0] chan_out;
  } slcb_core_state_t;

  typedef struct packed {
    logic ack_s1;
    logic ack_s2;
    logic req_tgl;
    logic pending;
    logic rsp_valid;
    slcb_link_req_t req;
    slcb_link_rsp_t rsp;
  } slcb_link_state_t;

  slcb_core_state_t r_reg;
  slcb_core_state_t r_next;
  slcb_link_state_t l_reg;
  slcb_link_state_t l_next;
  logic lrst_s1_reg;
  logic lrst_s2_reg;

  // Linear-11 word to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11_q(input logic [15:0] w);
    logic signed [47:0] m;
    logic signed [5:0] sh;
    m = 48'(signed'(w[10:0]));
    sh = 6'(signed'(w[15:11])) + 6'sd16;
    l11_q = m <<< sh;
  endfunction : l11_q

  // Coefficient (linear-11) times unsigned output word, saturated
  function automatic logic [15:0] discharge_level(input logic [15:0] coef,
                                                  input logic [15:0] target);
    logic signed [47:0] prod;
    logic signed [4:0] e;
    prod = 48'(signed'(coef[10:0])) * 48'(signed'({1'b0, target}));
    e = signed'(coef[15:11]);
    if (e < 0) begin
      prod = prod >>> 5'(-e);
    end else begin
      prod = prod <<< e;
    end
    if (prod < 0) begin
      discharge_level = 16'h0000;
    end else if (prod > 48'sh00000000ffff) begin
      discharge_level = 16'hffff;
    end else begin
      discharge_level = prod[15:0];
    end
  endfunction : discharge_level

  // Link-domain reset, released in step with the link clock
  always_ff @(posedge link_clock_i) begin
    lrst_s1_reg <= rst_n_i;
    lrst_s2_reg <= lrst_s1_reg;
  end

  // Link side: hold one request, toggle across, wait for the answer toggle
  always_comb begin
    l_next = l_reg;
    l_next.ack_s1 = r_reg.ack_tgl;
    l_next.ack_s2 = l_reg.ack_s1;
    l_next.rsp_valid = 1'b0;
    if (l_reg.pending && (l_reg.ack_s2 == l_reg.req_tgl)) begin
      l_next.pending = 1'b0;
      l_next.rsp_valid = 1'b1;
      // Core answer is frozen until the next toggle, so words cross safely
      l_next.rsp = r_reg.rsp;
    end else if (!l_reg.pending && link_req_valid_i) begin
      l_next.req = link_req_i;
      l_next.req_tgl = ~l_reg.req_tgl;
      l_next.pending = 1'b1;
    end
  end

  always_ff @(posedge link_clock_i) begin
    if (!lrst_s2_reg) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  assign link_ready_o = !l_reg.pending;
  assign link_rsp_valid_o = l_reg.rsp_valid;
  assign link_rsp_o = l_reg.rsp;

  // Core side
  always_comb begin
    slcb_link_req_t rq;
    slcb_chan_regs_t cr;
    logic busy;
    logic [15:0] sel;
    logic signed [47:0] vin_q;
    r_next = r_reg;
    rq = l_reg.req;
    cr = r_reg.chan[rq.page];
    busy = (r_reg.store != STORE_IDLE);
    sel = 16'h0000;
    vin_q = l11_q(input_sense_pin_i);
    r_next.req_s1 = l_reg.req_tgl;
    r_next.req_s2 = r_reg.req_s1;

    // Store busy timers
    if (busy) begin
      if (r_reg.store_count == 24'h000000) begin
        r_next.store = STORE_IDLE;
      end else begin
        r_next.store_count = r_reg.store_count - 24'h000001;
      end
    end

    if (r_reg.req_s2 != r_reg.req_seen) begin
      r_next.req_seen = r_reg.req_s2;
      r_next.ack_tgl = ~r_reg.ack_tgl;
      r_next.rsp = '0;
      r_next.rsp.ack = 1'b1;
      if (rq.code == CMD_COMMON_STATUS) begin
        r_next.rsp.ack = !rq.write;
        r_next.rsp.data[STATUS_NOT_BUSY_BIT] = !busy;
      end else if (busy) begin
        r_next.rsp.ack = 1'b0;
      end else begin
        case (rq.code)
          CMD_FORMAT: begin
            r_next.rsp.ack = !rq.write;
            r_next.rsp.data = {8'h00, FORMAT_VALUE};
          end
          CMD_TURN_ON_LEVEL: begin
            r_next.rsp.data = r_reg.turn_on_level;
            if (rq.write) r_next.turn_on_level = rq.data;
          end
          CMD_TURN_OFF_LEVEL: begin
            r_next.rsp.data = r_reg.turn_off_level;
            if (rq.write) r_next.turn_off_level = rq.data;
          end
          CMD_VIN_OV_FAULT: begin
            r_next.rsp.data = r_reg.vin_ov_fault;
            if (rq.write) r_next.vin_ov_fault = rq.data;
          end
          CMD_VIN_OV_WARN: begin
            r_next.rsp.data = r_reg.vin_ov_warn;
            if (rq.write) r_next.vin_ov_warn = rq.data;
          end
          CMD_VIN_UV_WARN: begin
            r_next.rsp.data = r_reg.vin_uv_warn;
            if (rq.write) r_next.vin_uv_warn = rq.data;
          end
          CMD_VIN_UV_FAULT: begin
            r_next.rsp.data = r_reg.vin_uv_fault;
            if (rq.write) r_next.vin_uv_fault = rq.data;
          end
          CMD_SERVO: begin
            r_next.rsp.data = cr.servo;
            if (rq.write) r_next.chan[rq.page].servo = rq.data;
          end
          CMD_CEILING: begin
            r_next.rsp.data = cr.ceiling;
            if (rq.write) r_next.chan[rq.page].ceiling = rq.data;
          end
          CMD_MARGIN_HIGH: begin
            r_next.rsp.data = cr.margin_high;
            if (rq.write) r_next.chan[rq.page].margin_high = rq.data;
          end
          CMD_MARGIN_LOW: begin
            r_next.rsp.data = cr.margin_low;
            if (rq.write) r_next.chan[rq.page].margin_low = rq.data;
          end
          CMD_OUT_OV_FAULT: begin
            r_next.rsp.data = cr.ov_fault;
            if (rq.write) r_next.chan[rq.page].ov_fault = rq.data;
          end
          CMD_OUT_OV_WARN: begin
            r_next.rsp.data = cr.ov_warn;
            if (rq.write) r_next.chan[rq.page].ov_warn = rq.data;
          end
          CMD_OUT_UV_WARN: begin
            r_next.rsp.data = cr.uv_warn;
            if (rq.write) r_next.chan[rq.page].uv_warn = rq.data;
          end
          CMD_OUT_UV_FAULT: begin
            r_next.rsp.data = cr.uv_fault;
            if (rq.write) r_next.chan[rq.page].uv_fault = rq.data;
          end
          CMD_GOOD_ON: begin
            r_next.rsp.data = cr.good_on;
            if (rq.write) r_next.chan[rq.page].good_on = rq.data;
          end
          CMD_GOOD_OFF: begin
            r_next.rsp.data = cr.good_off;
            if (rq.write) r_next.chan[rq.page].good_off = rq.data;
          end
          CMD_DISCHARGE: begin
            r_next.rsp.data = cr.discharge;
            if (rq.write) r_next.chan[rq.page].discharge = rq.data;
          end
          CMD_TRIM_CODE: begin
            r_next.rsp.data = {6'h00, cr.trim_code};
            if (rq.write) r_next.chan[rq.page].trim_code = rq.data[TRIM_CODE_BITS-1:0];
          end
          CMD_STORE_ERASE: begin
            // erase holds busy for its full time
            if (rq.write && (rq.data[7:0] == ERASE_KEY)) begin
              r_next.store = STORE_ERASE;
              r_next.store_count = 24'(ERASE_CYCLES - 1);
            end
          end
          CMD_STORE_DATA: begin
            // each word write busies the store
            if (rq.write) begin
              r_next.store = STORE_WRITE;
              r_next.store_count = 24'(WORD_PROG_CYCLES - 1);
            end
          end
          default: begin
            r_next.rsp.ack = 1'b0;
          end
        endcase
      end
    end

    r_next.vin_flags.ov_fault = vin_q > l11_q(r_reg.vin_ov_fault);
    r_next.vin_flags.ov_warn = vin_q > l11_q(r_reg.vin_ov_warn);
    r_next.vin_flags.uv_warn = vin_q < l11_q(r_reg.vin_uv_warn);
    r_next.vin_flags.uv_fault = vin_q < l11_q(r_reg.vin_uv_fault);

    if (!conversion_request_i || (vin_q < l11_q(r_reg.turn_off_level))) begin
      r_next.conv_on = 1'b0;
    end else if (!r_reg.sd_active && (vin_q > l11_q(r_reg.turn_on_level))) begin
      r_next.conv_on = 1'b1;
    end

    // untracked off now, tracked in turn
    if (r_reg.conv_on && !r_next.conv_on) begin
      r_next.out_en = r_reg.out_en & track_enable_i;
      r_next.sd_active = 1'b1;
      r_next.sd_idx = 2'h0;
      r_next.sd_count = 16'(TURN_OFF_CYCLES - 1);
    end else if (r_reg.sd_active) begin
      if (r_reg.sd_count == 16'h0000) begin
        r_next.out_en[r_reg.sd_idx] = 1'b0;
        r_next.sd_idx = r_reg.sd_idx + 2'h1;
        r_next.sd_count = 16'(TURN_OFF_CYCLES - 1);
        r_next.sd_active = (r_reg.sd_idx != 2'(NUM_CHAN - 1));
      end else begin
        r_next.sd_count = r_reg.sd_count - 16'h0001;
      end
    end else if (r_reg.conv_on) begin
      r_next.out_en = channel_run_i;
    end else begin
      r_next.out_en = '0;
    end

    for (int c = 0; c < NUM_CHAN; c++) begin
      case (margin_select_i[c])
        MARGIN_SEL_HIGH: sel = r_reg.chan[c].margin_high;
        MARGIN_SEL_LOW: sel = r_reg.chan[c].margin_low;
        default: sel = r_reg.chan[c].servo;
      endcase
      if (sel > r_reg.chan[c].ceiling) begin
        sel = r_reg.chan[c].ceiling;
      end
      r_next.chan_out[c].target = sel;
      r_next.chan_out[c].trim_code = r_reg.chan[c].trim_code;
      r_next.chan_out[c].ov_fault = vout_sense_i[c] > r_reg.chan[c].ov_fault;
      r_next.chan_out[c].ov_warn = vout_sense_i[c] > r_reg.chan[c].ov_warn;
      r_next.chan_out[c].uv_warn = vout_sense_i[c] < r_reg.chan[c].uv_warn;
      r_next.chan_out[c].uv_fault = vout_sense_i[c] < r_reg.chan[c].uv_fault;
      r_next.chan_out[c].discharged = vout_sense_i[c] <
        discharge_level(r_reg.chan[c].discharge, r_reg.chan[c].servo);
      if (vout_sense_i[c] >= r_reg.chan[c].good_on) begin
        r_next.good[c] = 1'b1;
      end else if (good_off_uses_undervoltage_i) begin
        if (vout_sense_i[c] <= r_reg.chan[c].uv_fault) r_next.good[c] = 1'b0;
      end else if (vout_sense_i[c] <= r_reg.chan[c].good_off) begin
        r_next.good[c] = 1'b0;
      end
      r_next.chan_out[c].power_good = r_next.good[c];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
      r_reg.turn_on_level <= RST_TURN_ON_LEVEL;
      r_reg.turn_off_level <= RST_TURN_OFF_LEVEL;
      r_reg.vin_ov_fault <= RST_VIN_OV_FAULT;
      r_reg.vin_ov_warn <= RST_VIN_OV_WARN;
      r_reg.vin_uv_warn <= RST_VIN_UV_WARN;
      r_reg.vin_uv_fault <= RST_VIN_UV_FAULT;
      r_reg.store <= STORE_IDLE;
      for (int c = 0; c < NUM_CHAN; c++) begin
        r_reg.chan[c] <= '{servo: RST_SERVO, ceiling: RST_CEILING,
                           margin_high: RST_MARGIN_HIGH, margin_low: RST_MARGIN_LOW,
                           ov_fault: RST_OUT_OV_FAULT, ov_warn: RST_OUT_OV_WARN,
                           uv_warn: RST_OUT_UV_WARN, uv_fault: RST_OUT_UV_FAULT,
                           good_on: RST_GOOD_ON, good_off: RST_GOOD_OFF,
                           discharge: RST_DISCHARGE, trim_code: RST_TRIM_CODE};
      end
    end else begin
      r_reg <= r_next;
    end
  end

  assign conversion_on_o = r_reg.conv_on;
  assign output_enable_pin_o = r_reg.out_en;
  assign vin_flags_o = r_reg.vin_flags;
  assign chan_out_o = r_reg.chan_out;
  assign store_busy_o = (r_reg.store != STORE_IDLE);

endmodule : slcb_bank

/* core/slcb_pkg.sv */
package slcb_pkg;

  localparam int NUM_CHAN = 4;

  // Command codes
  localparam logic [7:0] CMD_FORMAT = 8'h20;
  localparam logic [7:0] CMD_SERVO = 8'h21;
  localparam logic [7:0] CMD_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_TURN_ON_LEVEL = 8'h35;
  localparam logic [7:0] CMD_TURN_OFF_LEVEL = 8'h36;
  localparam logic [7:0] CMD_OUT_OV_FAULT = 8'h40;
  localparam logic [7:0] CMD_OUT_OV_WARN = 8'h42;
  localparam logic [7:0] CMD_OUT_UV_WARN = 8'h43;
  localparam logic [7:0] CMD_OUT_UV_FAULT = 8'h44;
  localparam logic [7:0] CMD_VIN_OV_FAULT = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_FAULT = 8'h59;
  localparam logic [7:0] CMD_GOOD_ON = 8'h5e;
  localparam logic [7:0] CMD_GOOD_OFF = 8'h5f;
  localparam logic [7:0] CMD_TRIM_CODE = 8'he0;
  localparam logic [7:0] CMD_DISCHARGE = 8'he9;
  localparam logic [7:0] CMD_COMMON_STATUS = 8'hd1;
  localparam logic [7:0] CMD_STORE_ERASE = 8'hbd;
  localparam logic [7:0] CMD_STORE_DATA = 8'hbf;

  // Fixed values and field positions
  localparam logic [7:0] FORMAT_VALUE = 8'h13;
  localparam logic [7:0] ERASE_KEY = 8'h2b;
  localparam int STATUS_NOT_BUSY_BIT = 6;
  localparam int TRIM_CODE_BITS = 10;
  localparam logic [1:0] MARGIN_SEL_HIGH = 2'h1;
  localparam logic [1:0] MARGIN_SEL_LOW = 2'h2;

  // Reset values
  localparam logic [15:0] RST_SERVO = 16'h2000;
  localparam logic [15:0] RST_CEILING = 16'h8000;
  localparam logic [15:0] RST_MARGIN_HIGH = 16'h219a;
  localparam logic [15:0] RST_MARGIN_LOW = 16'h1e66;
  localparam logic [15:0] RST_TURN_ON_LEVEL = 16'hd280;
  localparam logic [15:0] RST_TURN_OFF_LEVEL = 16'hd240;
  localparam logic [15:0] RST_OUT_OV_FAULT = 16'h2333;
  localparam logic [15:0] RST_OUT_OV_WARN = 16'h2266;
  localparam logic [15:0] RST_OUT_UV_WARN = 16'h1d9a;
  localparam logic [15:0] RST_OUT_UV_FAULT = 16'h1ccd;
  localparam logic [15:0] RST_VIN_OV_FAULT = 16'hd3c0;
  localparam logic [15:0] RST_VIN_OV_WARN = 16'hd380;
  localparam logic [15:0] RST_VIN_UV_WARN = 16'h8000;
  localparam logic [15:0] RST_VIN_UV_FAULT = 16'h8000;
  localparam logic [15:0] RST_GOOD_ON = 16'h1eb8;
  localparam logic [15:0] RST_GOOD_OFF = 16'h1e14;
  localparam logic [15:0] RST_DISCHARGE = 16'hc200;
  localparam logic [9:0] RST_TRIM_CODE = 10'h000;

  // Timing
  localparam longint unsigned CLK_FREQ_HZ = 64'd20000000;
  localparam longint unsigned WORD_PROG_TIME_US = 64'd170;
  localparam longint unsigned ERASE_TIME_MS = 64'd400;
  localparam longint unsigned TURN_OFF_DELAY_US = 64'd100;
  localparam int WORD_PROG_CYCLES =
    int'((WORD_PROG_TIME_US * CLK_FREQ_HZ + 64'd999999) / 64'd1000000);
  localparam int ERASE_CYCLES_DEFAULT = int'(ERASE_TIME_MS * CLK_FREQ_HZ / 64'd1000);
  localparam int TURN_OFF_CYCLES_DEFAULT =
    int'((TURN_OFF_DELAY_US * CLK_FREQ_HZ + 64'd999999) / 64'd1000000);

  typedef struct packed {
    logic write;
    logic [1:0] page;
    logic [7:0] code;
    logic [15:0] data;
  } slcb_link_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] data;
  } slcb_link_rsp_t;

  typedef struct packed {
    logic [15:0] servo;
    logic [15:0] ceiling;
    logic [15:0] margin_high;
    logic [15:0] margin_low;
    logic [15:0] ov_fault;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [15:0] uv_fault;
    logic [15:0] good_on;
    logic [15:0] good_off;
    logic [15:0] discharge;
    logic [9:0] trim_code;
  } slcb_chan_regs_t;

  typedef struct packed {
    logic ov_fault;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
    logic power_good;
    logic discharged;
    logic [15:0] target;
    logic [9:0] trim_code;
  } slcb_chan_out_t;

  typedef struct packed {
    logic ov_fault;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
  } slcb_vin_flags_t;

  typedef enum logic [1:0] {STORE_IDLE, STORE_ERASE, STORE_WRITE} slcb_store_state_t;

endpackage : slcb_pkg

/* sim/slcb_bank_chk.sv */
`timescale 1ns/10ps
module slcb_bank_chk
  import slcb_pkg::*;
#(
  parameter int ERASE_CYCLES = 50
) (
  // Clocks and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic link_clock_i,
  // Link
  input wire logic link_req_valid_i,
  input wire logic link_ready_o,
  input wire logic link_rsp_valid_o,
  input wire slcb_link_rsp_t link_rsp_o,
  // Control and status
  input wire logic conversion_request_i,
  input wire logic [NUM_CHAN-1:0] channel_run_i,
  input wire logic [NUM_CHAN-1:0] track_enable_i,
  input wire logic conversion_on_o,
  input wire logic [NUM_CHAN-1:0] output_enable_pin_o,
  input wire logic store_busy_o
);
  int busy_cnt;
  // Too long for a repetition, so count busy cycles
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !store_busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  a_rsp_pulse: assert property (
    @(posedge link_clock_i) disable iff (!rst_n_i) link_rsp_valid_o |=> !link_rsp_valid_o)
    else $error("Answer pulse too long");
  a_take_busy: assert property (
    @(posedge link_clock_i) disable iff (!rst_n_i)
    link_req_valid_i && link_ready_o |=> !link_ready_o) else $error("Ready stayed high");
  a_ready_back: assert property (
    @(posedge link_clock_i) disable iff (!rst_n_i) link_rsp_valid_o |=> link_ready_o)
    else $error("Ready not restored");
  a_answer_bound: assert property (
    @(posedge link_clock_i) disable iff (!rst_n_i)
    link_req_valid_i && link_ready_o |-> ##[2:10] link_rsp_valid_o) else $error("No answer");
  a_rsp_hold: assert property (
    @(posedge link_clock_i) disable iff (!rst_n_i)
    !$rose(link_rsp_valid_o) |-> $stable(link_rsp_o)) else $error("Answer changed");
  a_conv_request: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !conversion_request_i [*2] |=> !conversion_on_o) else $error("Converting unrequested");
  a_run_follow: assert property (
    @(posedge clock_i) disable iff (!rst_n_i) conversion_on_o && $past(conversion_on_o)
    |-> output_enable_pin_o == $past(channel_run_i)) else $error("Enables not following run");
  a_untracked_off: assert property (
    @(posedge clock_i) disable iff (!rst_n_i) $fell(conversion_on_o)
    |-> ##2 ((output_enable_pin_o & ~track_enable_i) == '0)) else $error("Untracked still on");
  a_busy_len: assert property (
    @(posedge clock_i) disable iff (!rst_n_i) $fell(store_busy_o) |-> busy_cnt inside
    {[ERASE_CYCLES-2:ERASE_CYCLES+1], [WORD_PROG_CYCLES-2:WORD_PROG_CYCLES+1]})
    else $error("Busy time wrong");
  c_take: cover property (@(posedge link_clock_i) link_req_valid_i && link_ready_o);
  c_busy: cover property (@(posedge clock_i) $rose(store_busy_o));
  c_shutdown: cover property (@(posedge clock_i) $fell(conversion_on_o));
endmodule : slcb_bank_chk
bind slcb_bank slcb_bank_chk #(.ERASE_CYCLES(ERASE_CYCLES)) u_slcb_bank_chk (.clock_i,
  .rst_n_i, .link_clock_i, .link_req_valid_i, .link_ready_o, .link_rsp_valid_o, .link_rsp_o,
  .conversion_request_i, .channel_run_i, .track_enable_i, .conversion_on_o,
  .output_enable_pin_o, .store_busy_o);

/* sim/slcb_host.sv */
`timescale 1ns/10ps
module slcb_host
  import slcb_pkg::*;
(
  // Answer side
  input wire logic link_clock_i,
  input wire logic link_ready_i,
  input wire logic link_rsp_valid_i,
  input wire slcb_link_rsp_t link_rsp_i,
  // Request side
  output logic link_req_valid_o,
  output slcb_link_req_t link_req_o
);
  initial begin
    link_req_valid_o = 1'b0;
    link_req_o = '0;
  end
  task automatic xfer(input logic wr, input logic [1:0] pg, input logic [7:0] cd,
                      input logic [15:0] wd, output slcb_link_rsp_t rsp);
    int n = 0;
    @(posedge link_clock_i);
    link_req_valid_o <= 1'b1;
    link_req_o <= '{write: wr, page: pg, code: cd, data: wd};
    @(negedge link_clock_i);
    while (link_ready_i !== 1'b1) @(negedge link_clock_i);
    @(posedge link_clock_i);
    link_req_valid_o <= 1'b0;
    // Inverted so a stale request never looks valid
    link_req_o <= ~link_req_o;
    do begin
      @(negedge link_clock_i);
      n++;
    end while (link_rsp_valid_i !== 1'b1 && n < 40);
    rsp = (n < 40) ? link_rsp_i : 'x;
  endtask : xfer
endmodule : slcb_host

/* sim/slcb_bank_bench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module slcb_bank_bench
  import slcb_pkg::*;
;
  localparam int ERASE_N = 50;
  localparam int OFF_N = 20;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic link_clock_i = 1'b0;
  logic req_valid, ready, rsp_valid, busy, conv_on;
  logic good_opt = 1'b0;
  logic conv_req = 1'b0;
  slcb_link_req_t req;
  slcb_link_rsp_t rsp, r;
  logic [15:0] vin = 16'h0000;
  logic [NUM_CHAN-1:0][15:0] vout = '0;
  logic [NUM_CHAN-1:0] run = '0, trk = '0, out_en;
  logic [NUM_CHAN-1:0][1:0] msel = '0;
  slcb_vin_flags_t vflags;
  slcb_chan_out_t [NUM_CHAN-1:0] chan;
  int n_errors = 0;
  int n_tests = 0;
  logic [7:0] cds [0:17] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h35, 8'h36, 8'h40, 8'h42, 8'h43,
    8'h44, 8'h55, 8'h57, 8'h58, 8'h59, 8'h5e, 8'h5f, 8'he0, 8'he9};
  logic [15:0] rsts [0:17] = '{16'h2000, 16'h8000, 16'h219a, 16'h1e66, 16'hd280, 16'hd240,
    16'h2333, 16'h2266, 16'h1d9a, 16'h1ccd, 16'hd3c0, 16'hd380, 16'h8000, 16'h8000,
    16'h1eb8, 16'h1e14, 16'h0000, 16'hc200};
  logic [15:0] vts [0:8] = '{16'h2334, 16'h2333, 16'h1e15, 16'h1e14, 16'h1d99, 16'h1ccc,
    16'h1eb8, 16'h1e14, 16'h1ccd};
  logic [4:0] exps [0:8] = '{5'h19, 5'h09, 5'h01, 5'h00, 5'h04, 5'h06, 5'h01, 5'h01, 5'h04};
  logic [7:0] bads [0:2] = '{CMD_FORMAT, CMD_COMMON_STATUS, 8'h30};
  always #25 clock_i = ~clock_i;
  initial begin
    #7;
    forever #15 link_clock_i = ~link_clock_i;
  end
  slcb_bank #(.ERASE_CYCLES(ERASE_N), .TURN_OFF_CYCLES(OFF_N)) u_slcb_bank (.clock_i,
    .rst_n_i, .link_clock_i, .link_req_valid_i(req_valid), .link_req_i(req),
    .link_ready_o(ready), .link_rsp_valid_o(rsp_valid), .link_rsp_o(rsp),
    .input_sense_pin_i(vin), .vout_sense_i(vout), .conversion_request_i(conv_req),
    .channel_run_i(run), .track_enable_i(trk), .margin_select_i(msel),
    .good_off_uses_undervoltage_i(good_opt), .conversion_on_o(conv_on),
    .output_enable_pin_o(out_en), .vin_flags_o(vflags), .chan_out_o(chan),
    .store_busy_o(busy));
  slcb_host u_slcb_host (.link_clock_i, .link_ready_i(ready), .link_rsp_valid_i(rsp_valid),
    .link_rsp_i(rsp), .link_req_valid_o(req_valid), .link_req_o(req));
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  task automatic acc(input logic wr, input logic [1:0] pg, input logic [7:0] cd,
                     input logic [15:0] wd);
    u_slcb_host.xfer(wr, pg, cd, wd, r);
    // Back on a system edge so later drives land there
    @(posedge clock_i);
  endtask : acc
  task automatic rd_chk(input logic [1:0] pg, input logic [7:0] cd, input logic [15:0] ex);
    acc(1'b0, pg, cd, 16'h0000);
    `CHK(r, {1'b1, ex})
  endtask : rd_chk
  task automatic poll_idle();
    int n = 0;
    do begin
      acc(1'b0, 2'h0, CMD_COMMON_STATUS, 16'h0000);
      `CHK(r.ack, 1'b1)
      n++;
    end while (r.data[STATUS_NOT_BUSY_BIT] !== 1'b1 && n < 2000);
    `CHK({r.data[STATUS_NOT_BUSY_BIT], busy}, 2'b10)
  endtask : poll_idle
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    #3000000;
    n_errors++;
    finish_test();
  end
  initial begin
    tick(5);
    rst_n_i <= 1'b1;
    tick(4);
    rd_chk(2'h0, CMD_FORMAT, {8'h00, FORMAT_VALUE});
    for (int i = 0; i < 18; i++) begin
      rd_chk(2'h1, cds[i], rsts[i]);
    end
    $display("Reset values done");
    for (int i = 0; i < 9; i++) begin
      good_opt <= (i > 6);
      vout <= {NUM_CHAN{vts[i]}};
      tick(3);
      `CHK(chan[3][31:27], exps[i])
    end
    `CHK({chan[3].discharged, chan[3].target}, {1'b1, RST_SERVO})
    vout <= {NUM_CHAN{16'h4000}};
    tick(3);
    `CHK(chan[3].discharged, 1'b0)
    $display("Telemetry done");
    run <= 4'hf;
    trk <= 4'h1;
    conv_req <= 1'b1;
    vin <= RST_TURN_ON_LEVEL;
    tick(4);
    `CHK(conv_on, 1'b0)
    vin <= 16'hd3c1;
    tick(4);
    `CHK({conv_on, out_en, vflags}, {1'b1, 4'hf, 4'hc})
    vin <= 16'hd200;
    tick(6);
    `CHK({conv_on, out_en, vflags}, {1'b0, 4'h1, 4'h0})
    tick(OFF_N + 4);
    `CHK(out_en, 4'h0)
    $display("Conversion done");
    for (int i = 0; i < 18; i++) begin
      acc(1'b1, 2'h2, cds[i], rsts[i] ^ 16'h0101);
      rd_chk(2'h2, cds[i], rsts[i] ^ 16'h0101);
    end
    rd_chk(2'h0, CMD_SERVO, RST_SERVO);
    vin <= 16'h0000;
    tick(3);
    `CHK(vflags, 4'h3)
    msel[2] <= MARGIN_SEL_HIGH;
    tick(3);
    `CHK({chan[2].target, chan[2].trim_code}, {16'h209b, 10'h101})
    acc(1'b1, 2'h2, CMD_CEILING, 16'h2000);
    tick(3);
    `CHK(chan[2].target, 16'h2000)
    msel[2] <= MARGIN_SEL_LOW;
    tick(3);
    `CHK(chan[2].target, 16'h1f67)
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 2'h0, bads[i], 16'h0000);
      `CHK(r.ack, 1'b0)
    end
    acc(1'b0, 2'h0, 8'h30, 16'h0000);
    `CHK(r.ack, 1'b0)
    $display("Commands done");
    acc(1'b1, 2'h0, CMD_STORE_ERASE, 16'h0000);
    `CHK({r.ack, busy}, 2'b10)
    acc(1'b1, 2'h0, CMD_STORE_ERASE, {8'h00, ERASE_KEY});
    `CHK(r.ack, 1'b1)
    acc(1'b0, 2'h0, CMD_SERVO, 16'h0000);
    `CHK(r.ack, 1'b0)
    acc(1'b0, 2'h0, CMD_COMMON_STATUS, 16'h0000);
    `CHK({r.ack, r.data[STATUS_NOT_BUSY_BIT], busy}, 3'b101)
    poll_idle();
    acc(1'b1, 2'h0, CMD_STORE_DATA, 16'h1234);
    `CHK(r.ack, 1'b1)
    acc(1'b0, 2'h0, CMD_STORE_DATA, 16'h0000);
    `CHK(r.ack, 1'b0)
    poll_idle();
    rd_chk(2'h0, CMD_STORE_DATA, 16'h0000);
    $display("Store done");
    finish_test();
  end
endmodule : slcb_bank_bench
